// >>> verilog/ioc_pkg.sv
//------------------------------------------------------------
// Function
// - hf control bit 7 enables the high-frequency oscillator.
// - hf control bit 6 reads 1 only while hf runs at programmed rate.
// - hf control bits 5..2 read zero; writes to them ignored.
// - hf divider codes 00..11 give system clock divided by 8,4,2,1.
// - after reset the internal hf oscillator is the system clock source.
// - lf oscillator runs at nominal 80 kHz before post-division.
// - lf divider codes 00..11 divide lf output by 8,4,2,1.
// - lf fine-tune field bits 5..2; 0000b is the reference point.
// - each fine-tune step changes lf period by about 3 percent.
// - timer 2 captures on lf falling edge, timer 3 on rising edge.
// - each capture copies the 16-bit timer count into its reload pair.
//------------------------------------------------------------
package ioc_pkg;

  // register offsets
  localparam logic [7:0] HF_CTRL_ADDR = 8'hb2;
  localparam logic [7:0] LF_CTRL_ADDR = 8'he3;
  localparam logic [7:0] CAP_CTRL_ADDR = 8'hf0;
  localparam logic [7:0] T2_RL_LO_ADDR = 8'hf1;
  localparam logic [7:0] T2_RL_HI_ADDR = 8'hf2;
  localparam logic [7:0] T3_RL_LO_ADDR = 8'hf3;
  localparam logic [7:0] T3_RL_HI_ADDR = 8'hf4;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'hf5;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hf6;

  // field positions
  localparam int EN_BIT = 7;
  localparam int RDY_BIT = 6;
  localparam int TUNE_LSB = 2;
  localparam int DIV_LSB = 0;
  localparam int IRQ_HF_RDY = 0;
  localparam int IRQ_LF_RDY = 1;
  localparam int IRQ_T2_CAP = 2;
  localparam int IRQ_T3_CAP = 3;

  // reset values
  localparam logic [7:0] HF_CTRL_RST = 8'hc0;
  localparam logic [7:0] LF_CTRL_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HF_SETTLE_NS = 1000;
  localparam int HF_SETTLE_CYC = (HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_FREQ_HZ = 80000;
  localparam int LF_BASE_CYC = 1000000000 / (LF_FREQ_HZ * CLK_PERIOD_NS);
  localparam int LF_STEP_PCT = 3;
  localparam int LF_STEP_CYC = LF_BASE_CYC * LF_STEP_PCT / 100;
  localparam int LF_STABLE_US = 100;
  localparam int LF_STABLE_CYC = LF_STABLE_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ioc_bus_t;

  // divider code to terminal count (divide by 8,4,2,1)
  function automatic logic [2:0] div_lim(input logic [1:0] code);
    case (code)
      2'h0: div_lim = 3'h7;
      2'h1: div_lim = 3'h3;
      2'h2: div_lim = 3'h1;
      default: div_lim = 3'h0;
    endcase
  endfunction : div_lim

endpackage : ioc_pkg

// >>> verilog/ioc_osc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ioc_osc_ctrl
  import ioc_pkg::*;
#(
  parameter int unsigned LF_STABLE_CYCLES = LF_STABLE_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port
  input wire ioc_bus_t bus_in,
  output logic [7:0] rdata_out,
  // clock outputs
  output logic system_clock_en_out,
  output logic clk_src_hf_out,
  output logic lf_clk_out,
  output logic hf_en_out,
  output logic lf_en_out,
  // interrupt
  output logic irq_out
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  logic hf_en, next_hf_en;
  logic [1:0] hf_div, next_hf_div;
  logic lf_en, next_lf_en;
  logic [3:0] lf_tune, next_lf_tune;
  logic [1:0] lf_div, next_lf_div;
  logic [1:0] cap_en, next_cap_en;
  logic [3:0] mask, next_mask;
  logic [3:0] stat, next_stat;
  logic [7:0] rdata, next_rdata;
  logic [15:0] t2_rl, next_t2_rl;
  logic [15:0] t3_rl, next_t3_rl;
  logic src_hf, next_src_hf;

  logic [7:0] hf_set, next_hf_set;
  logic hf_rdy, next_hf_rdy;
  logic hf_rise, next_hf_rise;
  logic [2:0] hf_dv, next_hf_dv;
  logic system_clock_en, next_system_clock_en;
  logic [15:0] lf_set, next_lf_set;
  logic lf_rdy, next_lf_rdy;
  logic lf_rise, next_lf_rise;
  logic [10:0] lf_ph, next_lf_ph;
  logic lf_raw, next_lf_raw;
  logic [2:0] lf_tc, next_lf_tc;
  logic lf_out, next_lf_out;
  logic lf_q, next_lf_q;
  logic [15:0] t2_cnt, next_t2_cnt;
  logic [15:0] t3_cnt, next_t3_cnt;

  logic [10:0] lf_half_m1;
  logic cap2;
  logic cap3;
  logic [3:0] ev;

  // period grows by one step per tune unit
  // step is three percent of the base period
  assign lf_half_m1 = 11'((LF_BASE_CYC + int'(lf_tune) * LF_STEP_CYC) / 2 - 1);
  // falling edge to timer 2, rising to timer 3
  assign cap2 = cap_en[0] & lf_q & ~lf_out;
  assign cap3 = cap_en[1] & ~lf_q & lf_out;
  assign ev = {cap3, cap2, lf_rise, hf_rise};

  //------------------------------------------------------------
  // register file and interrupts
  //------------------------------------------------------------
  always_comb begin
    next_hf_en = hf_en;
    next_hf_div = hf_div;
    next_lf_en = lf_en;
    next_lf_tune = lf_tune;
    next_lf_div = lf_div;
    next_cap_en = cap_en;
    next_mask = mask;
    next_stat = stat;
    next_t2_rl = t2_rl;
    next_t3_rl = t3_rl;
    next_src_hf = src_hf;
    next_rdata = 8'h00;
    if (bus_in.wr) begin
      case (bus_in.addr)
        HF_CTRL_ADDR: begin
          next_hf_en = bus_in.wdata[EN_BIT];
          next_hf_div = bus_in.wdata[DIV_LSB +: 2];
        end
        LF_CTRL_ADDR: begin
          next_lf_en = bus_in.wdata[EN_BIT];
          next_lf_tune = bus_in.wdata[TUNE_LSB +: 4];
          next_lf_div = bus_in.wdata[DIV_LSB +: 2];
        end
        CAP_CTRL_ADDR: next_cap_en = bus_in.wdata[1:0];
        IRQ_MASK_ADDR: next_mask = bus_in.wdata[3:0];
        default: ;
      endcase
    end
    if (bus_in.rd) begin
      case (bus_in.addr)
        // ready flag; bits 5..2 read zero
        HF_CTRL_ADDR: next_rdata = {hf_en, hf_rdy, 4'h0, hf_div};
        LF_CTRL_ADDR: next_rdata = {lf_en, lf_rdy, lf_tune, lf_div};
        CAP_CTRL_ADDR: next_rdata = {6'h00, cap_en};
        T2_RL_LO_ADDR: next_rdata = t2_rl[7:0];
        T2_RL_HI_ADDR: next_rdata = t2_rl[15:8];
        T3_RL_LO_ADDR: next_rdata = t3_rl[7:0];
        T3_RL_HI_ADDR: next_rdata = t3_rl[15:8];
        IRQ_STAT_ADDR: next_rdata = {4'h0, stat};
        IRQ_MASK_ADDR: next_rdata = {4'h0, mask};
        default: next_rdata = 8'h00;
      endcase
      if (bus_in.addr == IRQ_STAT_ADDR) begin
        next_stat = 4'h0;
      end
    end
    // set wins over the read clear
    next_stat = next_stat | ev;
    if (cap2) begin
      next_t2_rl = t2_cnt;
    end
    if (cap3) begin
      next_t3_rl = t3_cnt;
    end
    // no other source in this block, so hf stays selected
    next_src_hf = 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hf_en <= HF_CTRL_RST[EN_BIT];
      hf_div <= HF_CTRL_RST[DIV_LSB +: 2];
      lf_en <= LF_CTRL_RST[EN_BIT];
      lf_tune <= LF_CTRL_RST[TUNE_LSB +: 4];
      lf_div <= LF_CTRL_RST[DIV_LSB +: 2];
      cap_en <= 2'h0;
      mask <= 4'h0;
      stat <= 4'h0;
      t2_rl <= 16'h0000;
      t3_rl <= 16'h0000;
      src_hf <= 1'b1;
      rdata <= 8'h00;
    end else begin
      hf_en <= next_hf_en;
      hf_div <= next_hf_div;
      lf_en <= next_lf_en;
      lf_tune <= next_lf_tune;
      lf_div <= next_lf_div;
      cap_en <= next_cap_en;
      mask <= next_mask;
      stat <= next_stat;
      t2_rl <= next_t2_rl;
      t3_rl <= next_t3_rl;
      src_hf <= next_src_hf;
      rdata <= next_rdata;
    end
  end

  //------------------------------------------------------------
  // oscillator models and timers
  //------------------------------------------------------------
  always_comb begin
    next_hf_set = 8'h00;
    next_hf_dv = 3'h0;
    next_system_clock_en = 1'b0;
    next_lf_set = 16'h0000;
    next_lf_ph = 11'h000;
    next_lf_raw = 1'b0;
    next_lf_tc = 3'h0;
    next_lf_out = 1'b0;
    if (hf_en) begin
      next_hf_set = (hf_set == 8'(HF_SETTLE_CYC)) ? hf_set : hf_set + 8'h01;
    end
    // ready after settling, dropped one cycle after disable
    next_hf_rdy = hf_en && (hf_set == 8'(HF_SETTLE_CYC));
    next_hf_rise = next_hf_rdy && !hf_rdy;
    // enable pulse every 8,4,2,1 cycles; >= copes with a shrunk divider
    if (hf_rdy) begin
      if (hf_dv >= div_lim(hf_div)) begin
        next_system_clock_en = 1'b1;
      end else begin
        next_hf_dv = hf_dv + 3'h1;
      end
    end
    if (lf_en) begin
      next_lf_set = (lf_set == 16'(LF_STABLE_CYCLES)) ? lf_set : lf_set + 16'h0001;
    end
    next_lf_rdy = lf_en && (lf_set == 16'(LF_STABLE_CYCLES));
    next_lf_rise = next_lf_rdy && !lf_rdy;
    if (lf_en) begin
      next_lf_raw = lf_raw;
      next_lf_tc = lf_tc;
      next_lf_out = lf_out;
      if (lf_ph >= lf_half_m1) begin
        next_lf_raw = ~lf_raw;
        if (lf_tc >= div_lim(lf_div)) begin
          next_lf_tc = 3'h0;
          next_lf_out = ~lf_out;
        end else begin
          next_lf_tc = lf_tc + 3'h1;
        end
      end else begin
        next_lf_ph = lf_ph + 11'h001;
      end
    end
    next_lf_q = lf_out;
    // free-running reference time base for calibration
    next_t2_cnt = t2_cnt + 16'h0001;
    next_t3_cnt = t3_cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hf_set <= 8'h00;
      hf_rdy <= 1'b0;
      hf_rise <= 1'b0;
      hf_dv <= 3'h0;
      system_clock_en <= 1'b0;
      lf_set <= 16'h0000;
      lf_rdy <= 1'b0;
      lf_rise <= 1'b0;
      lf_ph <= 11'h000;
      lf_raw <= 1'b0;
      lf_tc <= 3'h0;
      lf_out <= 1'b0;
      lf_q <= 1'b0;
      t2_cnt <= 16'h0000;
      t3_cnt <= 16'h0000;
    end else begin
      hf_set <= next_hf_set;
      hf_rdy <= next_hf_rdy;
      hf_rise <= next_hf_rise;
      hf_dv <= next_hf_dv;
      system_clock_en <= next_system_clock_en;
      lf_set <= next_lf_set;
      lf_rdy <= next_lf_rdy;
      lf_rise <= next_lf_rise;
      lf_ph <= next_lf_ph;
      lf_raw <= next_lf_raw;
      lf_tc <= next_lf_tc;
      lf_out <= next_lf_out;
      lf_q <= next_lf_q;
      t2_cnt <= next_t2_cnt;
      t3_cnt <= next_t3_cnt;
    end
  end

  assign rdata_out = rdata;
  assign system_clock_en_out = system_clock_en;
  assign clk_src_hf_out = src_hf;
  assign lf_clk_out = lf_out;
  assign hf_en_out = hf_en;
  assign lf_en_out = lf_en;
  assign irq_out = |(stat & mask);

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_hf_unused_zero: assert property (
    bus_in.rd && bus_in.addr == HF_CTRL_ADDR |=> rdata_out[5:2] == 4'h0)
    else $error("hf control unused bits not zero");

  a_hf_ready_off: assert property (
    !hf_en_out |=> !hf_rdy)
    else $error("hf ready while disabled");

  a_hf_settle_wait: assert property (
    $rose(hf_en_out) |-> !hf_rdy [*8])
    else $error("hf ready before settling");

  a_system_clock_div_8: assert property (
    system_clock_en_out && hf_div == 2'h0 && !bus_in.wr |=> (!system_clock_en_out || hf_div != 2'h0) [*7])
    else $error("divide by 8 pulse spacing wrong");

  a_system_clock_div_1: assert property (
    hf_rdy && hf_div == 2'h3 && $past(hf_rdy) && $past(hf_div) == 2'h3 |-> system_clock_en_out)
    else $error("divide by 1 missed a pulse");

  a_lf_stable_off: assert property (
    !lf_en_out |=> !lf_rdy)
    else $error("lf stable while disabled");

  a_lf_half_period: assert property (
    lf_en && lf_ph == lf_half_m1 |=> lf_raw != $past(lf_raw) && lf_ph == 11'h000)
    else $error("lf half period wrong");

  a_t2_fall_cap: assert property (
    cap_en[0] && $fell(lf_clk_out) |=> t2_rl == $past(t2_cnt))
    else $error("timer 2 capture missed");

  a_t3_rise_cap: assert property (
    cap_en[1] && $rose(lf_clk_out) |=> t3_rl == $past(t3_cnt))
    else $error("timer 3 capture missed");

  a_src_after_reset: assert property (
    $fell(rst_in) |-> clk_src_hf_out)
    else $error("hf not selected after reset");

endmodule : ioc_osc_ctrl
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ioc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  ioc_bus_t bus = '0;
  logic [7:0] rdata_out;
  logic system_clock_en_out, clk_src_hf_out, lf_clk_out, hf_en_out, lf_en_out, irq_out;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  logic [7:0] got_q[$];
  logic rd_seen = 1'b0;
  int p, a, tune;
  logic [15:0] c0, c1, pe;

  always #5 ref_clk_in = ~ref_clk_in;

  ioc_osc_ctrl #(.LF_STABLE_CYCLES(20)) uut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata_out),
    .system_clock_en_out(system_clock_en_out), .clk_src_hf_out(clk_src_hf_out), .lf_clk_out(lf_clk_out),
    .hf_en_out(hf_en_out), .lf_en_out(lf_en_out), .irq_out(irq_out));

  //----------------------------------------
  // checking and closing
  //----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      results();
    end
    if (rd_seen) begin
      // care mask zero: keep the byte, or drop it when the note is zero
      if (exp_q[0][15:8] == 8'h00) begin
        if (exp_q[0][0]) got_q.push_back(rdata_out);
      end else chk({8'h00, rdata_out & exp_q[0][15:8]}, {8'h00, exp_q[0][7:0] & exp_q[0][15:8]});
      void'(exp_q.pop_front());
    end
    rd_seen <= bus.rd;
  end

  //----------------------------------------
  // bus tasks
  //----------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    @(posedge ref_clk_in);
    bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus <= '0;
  endtask : rd

  // cycles between two system_clock pulses or two lf edges
  task automatic meas(input bit lf, output int n);
    logic prev;
    n = 0;
    for (int s = 0; s < 2; s++) begin
      prev = lf_clk_out;
      n = 0;
      repeat (12000) begin
        @(posedge ref_clk_in);
        #1;
        n++;
        if (lf ? (lf_clk_out !== prev) : (system_clock_en_out === 1'b1)) break;
      end
    end
  endtask : meas

  task automatic wait_irq;
    repeat (3000) begin
      @(posedge ref_clk_in);
      #1;
      if (irq_out === 1'b1) break;
    end
  endtask : wait_irq

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    a = $urandom(32'hee8c);
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk({12'h000, clk_src_hf_out, hf_en_out, lf_en_out, irq_out}, 16'h000c);
    repeat (110) @(posedge ref_clk_in);
    rd(HF_CTRL_ADDR, 8'hff, HF_CTRL_RST);
    rd(8'h10, 8'hff, 8'h00);
    $display("test reset done");
    // divider codes with random junk in unused bits
    for (int c = 0; c < 4; c++) begin
      a = $urandom;
      wr(HF_CTRL_ADDR, {1'b1, a[6:2], c[1:0]});
      rd(HF_CTRL_ADDR, 8'hff, {6'h30, c[1:0]});
      meas(1'b0, p);
      chk(16'(p), 16'd8 >> c);
    end
    wr(HF_CTRL_ADDR, 8'h03);
    // ready trails the disable by one cycle, the last pulse by two
    repeat (2) @(posedge ref_clk_in);
    p = 0;
    repeat (20) begin
      @(posedge ref_clk_in);
      #1;
      p += int'(system_clock_en_out);
    end
    chk({hf_en_out, 15'(p)}, 16'h0000);
    rd(HF_CTRL_ADDR, 8'hff, 8'h03);
    wr(HF_CTRL_ADDR, 8'h80);
    repeat (110) @(posedge ref_clk_in);
    rd(HF_CTRL_ADDR, 8'hff, 8'hc0);
    $display("test hf done");
    wr(LF_CTRL_ADDR, 8'h83);
    rd(LF_CTRL_ADDR, 8'hff, 8'h83);
    repeat (25) @(posedge ref_clk_in);
    rd(LF_CTRL_ADDR, 8'hff, 8'hc3);
    chk({15'h0, lf_en_out}, 16'h0001);
    // lf half period per divider code
    for (int c = 3; c >= 0; c--) begin
      wr(LF_CTRL_ADDR, {6'h20, c[1:0]});
      meas(1'b1, p);
      chk(16'(p), 16'(LF_BASE_CYC / 2) << (3 - c));
    end
    $display("test lf done");
    tune = $urandom_range(15, 1);
    wr(LF_CTRL_ADDR, {2'b10, tune[3:0], 2'b11});
    wr(CAP_CTRL_ADDR, 8'h03);
    wr(IRQ_MASK_ADDR, 8'h00);
    repeat (2000) @(posedge ref_clk_in);
    #1;
    chk({15'h0, irq_out}, 16'h0000);
    rd(IRQ_STAT_ADDR, 8'h0f, 8'h0f);
    for (int k = 0; k < 2; k++) begin
      wr(IRQ_MASK_ADDR, 8'h04 << k);
      rd(IRQ_STAT_ADDR, 8'h00, 8'h00);
      for (int j = 0; j < 2; j++) begin
        wait_irq();
        // timer 2 on falling edge, timer 3 on rising
        chk({14'h0, irq_out, lf_clk_out}, {14'h0, 1'b1, k[0]});
        rd(k ? T3_RL_LO_ADDR : T2_RL_LO_ADDR, 8'h00, 8'h01);
        rd(k ? T3_RL_HI_ADDR : T2_RL_HI_ADDR, 8'h00, 8'h01);
        rd(IRQ_STAT_ADDR, 8'h04 << k, 8'h04 << k);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk({15'h0, irq_out}, 16'h0000);
      end
      c0 = {got_q[1], got_q[0]};
      c1 = {got_q[3], got_q[2]};
      got_q.delete();
      // half periods may round, so allow one cycle
      pe = 16'(LF_BASE_CYC + tune * LF_STEP_CYC);
      c1 = c1 - c0;
      chk((c1 + 16'h0001 - pe <= 16'h0002) ? pe : c1, pe);
    end
    $display("test capture done");
    results();
  end
endmodule : testbench
`default_nettype wire
